// >>> design/sfc_params.svh
// constants of the serial flash command front end and its host controller
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_OP_NO_EFFECT    8'h00
`define SFC_OP_RESET_ARM    8'h66
`define SFC_OP_RESET        8'h99
`define SFC_OP_QUAD_ENTER   8'h38
`define SFC_OP_QUAD_EXIT    8'hff
`define SFC_OP_READ         8'h03
`define SFC_OP_FAST_READ    8'h0b
`define SFC_OP_DUAL_READ    8'hbb
`define SFC_OP_ID_LOCKOUT   8'h85
`define SFC_OP_SECTOR_ERASE 8'h20
`define SFC_OP_BLOCK_ERASE  8'hd8
`define SFC_OP_SUSPEND      8'hb0
`define SFC_OP_RESUME       8'h30
`define SFC_CONT_NIBBLE     4'ha
`define SFC_STATUS_RST      8'h00
`define SFC_STATUS_KEEP     8'h30
`define SFC_ID_LOCK_BIT     5
`define SFC_CFG_RST         8'h00
`define SFC_QUAD_IO_CFG_BIT 1
`define SFC_BURST_RST       2'h0
`define SFC_TOP_BLOCK       8'hff
`define SFC_SECTOR_MASK     24'hff_f000
`define SFC_BLK64_MASK      24'hff_0000
`define SFC_BLK32_MASK      24'hff_8000
`define SFC_BLK8_MASK       24'hff_e000
`define SFC_REG_CMD         5'h00
`define SFC_REG_ADDR        5'h04
`define SFC_REG_STAT        5'h08
`define SFC_REG_RDATA       5'h0c
`define SFC_CMD_START       31
`define SFC_CMD_SKIP_OP     25
`define SFC_CMD_NRD_LSB     17
`define SFC_CMD_NDUM_LSB    14
`define SFC_CMD_NADR_LSB    12
`define SFC_CMD_DATL_LSB    10
`define SFC_CMD_OPL_LSB     8
`define SFC_CLK_NS          10
`define SFC_READ_FMAX_MHZ   40
`define SFC_READ_PERIOD_NS  (1000 / `SFC_READ_FMAX_MHZ)
`define SFC_READ_HALF_MIN   \
  ((`SFC_READ_PERIOD_NS + 2 * `SFC_CLK_NS - 1) / (2 * `SFC_CLK_NS))
`endif

// >>> design/sfc_pkg.sv
// types and shared helpers of the serial flash front end
package sfc_pkg;
  typedef enum logic [2:0] {
    SFC_IDLE, SFC_OPC, SFC_ADDR, SFC_MODE, SFC_DUMMY, SFC_DATA, SFC_END,
    SFC_SKIP
  } sfc_phase_e;
  typedef enum logic [2:0] {
    SFC_H_IDLE, SFC_H_OP, SFC_H_ADR, SFC_H_DUM, SFC_H_RD, SFC_H_END,
    SFC_H_GAP
  } sfc_hstage_e;
  typedef struct packed {
    logic        cs1;
    logic        cs2;
    logic        sck1;
    logic        sck2;
    logic        sck3;
    logic [3:0]  io1;
    logic [3:0]  io2;
    sfc_phase_e  phase;
    logic [2:0]  w;
    logic [2:0]  bcnt;
    logic [7:0]  sh;
    logic [7:0]  opc;
    logic [23:0] addr;
    logic [1:0]  nleft;
    logic [2:0]  ocnt;
    logic [7:0]  obyte;
    logic        quad;
    logic        cont_arm;
    logic        in_cont;
    logic        rst_arm;
    logic [7:0]  status;
    logic [7:0]  cfg;
    logic [1:0]  burst;
    logic [3:0]  sio_o;
    logic [3:0]  sio_oe;
    logic        erase_req;
    logic [23:0] erase_addr;
    logic        suspend;
    logic        resume;
    logic        abort;
    logic        sw_reset;
  } sfc_dev_s;
  typedef struct packed {
    logic [3:0]  io1;
    logic [3:0]  io2;
    sfc_hstage_e stage;
    logic        sck;
    logic        cs_n;
    logic [7:0]  div;
    logic [2:0]  w;
    logic [2:0]  bcnt;
    logic [7:0]  sh;
    logic [7:0]  nleft;
    logic [31:0] cmd;
    logic [31:0] addr_reg;
    logic [23:0] outsr;
    logic [31:0] rdata;
    logic        busy;
    logic [3:0]  sio_o;
    logic [3:0]  sio_oe;
    logic        a_act;
    logic        a_wr;
    logic [4:0]  a_off;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } sfc_host_s;

  // bits carried per serial clock for a lane code
  function automatic logic [2:0] sfc_lanes(input logic [1:0] code);
    return (code == 2'd0) ? 3'd1 : (code == 2'd1) ? 3'd2 : 3'd4;
  endfunction

  function automatic logic [7:0] sfc_shift_in(input logic [7:0] sh,
                                              input logic [3:0] io,
                                              input logic [2:0] w);
    if (w == 3'd1) return {sh[6:0], io[0]};
    if (w == 3'd2) return {sh[5:0], io[1:0]};
    return {sh[3:0], io};
  endfunction
endpackage

// >>> design/sfc_link_if.sv
// serial link between the host controller and the flash front end
`timescale 1ns/10ps
interface sfc_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] sio;
  // undriven lines float high
  assign sio = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o)
             | (~dev_oe & ~host_oe);
  modport host (output cs_n, output sck, output host_o, output host_oe,
                input sio);
  modport dev (input cs_n, input sck, input sio, output dev_o,
               output dev_oe);
endinterface

// >>> design/sfc_dev.sv
// flash side command front end: opcode decode, framing, read streaming
// Operation
// - opcode takes 2 or 8 clocks by mode
// - address, mode, data: 2, 4 or 8 clocks
// - no-effect opcode only cancels reset arm
// - host sends arm then reset, separate frames
// - reset needs arm directly before it
// - reset: single-bit, burst 8, status, config
// - reset aborts running program or erase
// - plain read only in single-bit mode
// - host sends opcode, 24-bit address MSB first
// - read streams, pointer wraps, stops on deselect
// - quad enter opcode latches four-bit mode
// - quad exit returns to single-bit mode
// - in continuation, first exit only ends continuation
// - host drives unused lines to defined level
// - id lockout accepted in both modes
// - sector erase decodes down to bit 12
// - block erase decodes by block size
// - host sets quad config before quad commands; nothing here sets config_reg bit 1, and quad enter ignores it
// - dual read: four clocks per byte
// - mode nibble A after fast read in four-bit mode makes next frame read
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_dev
  import sfc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  sfc_link_if.dev          link,
  input  wire logic        prog_busy,
  output logic             quad_mode,
  output logic             cont_read,
  output logic [7:0]       status,
  output logic [7:0]       config_reg,
  output logic [1:0]       burst_len,
  output logic             erase_req,
  output logic [23:0]      erase_addr,
  output logic             suspend_req,
  output logic             resume_req,
  output logic             op_abort,
  output logic             sw_reset_done
);
  sfc_dev_s   s;
  sfc_dev_s   n;
  logic       rise;
  logic       fall;
  logic [7:0] b;
  logic [7:0] ob;

  // stand-in array contents; the array itself sits outside this block
  function automatic logic [7:0] array_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction

  function automatic logic [23:0] block_base(input logic [23:0] a);
    logic lo;
    logic hi;
    lo = (a[23:16] == 8'h00);
    hi = (a[23:16] == `SFC_TOP_BLOCK);
    if ((lo && !a[15]) || (hi && a[15])) return a & `SFC_BLK8_MASK;
    if (lo || hi) return a & `SFC_BLK32_MASK;
    return a & `SFC_BLK64_MASK;
  endfunction

  always_comb begin
    n = s;
    n.erase_req = 1'b0;
    n.suspend = 1'b0;
    n.resume = 1'b0;
    n.abort = 1'b0;
    n.sw_reset = 1'b0;
    n.cs1 = link.cs_n;
    n.cs2 = s.cs1;
    n.sck1 = link.sck;
    n.sck2 = s.sck1;
    n.sck3 = s.sck2;
    n.io1 = link.sio;
    n.io2 = s.io1;
    rise = s.sck2 & ~s.sck3;
    fall = ~s.sck2 & s.sck3;
    b = sfc_shift_in(s.sh, s.io2, s.w);
    ob = (s.ocnt == 3'd0) ? array_byte(s.addr) : s.obyte;
    if (s.cs2) begin
      n.sio_oe = 4'h0;
      n.phase = SFC_IDLE;
      // act only when deselected right after the last byte
      if (s.phase == SFC_END) begin
        case (s.opc)
          `SFC_OP_RESET_ARM: n.rst_arm = 1'b1;
          `SFC_OP_RESET: begin
            if (s.rst_arm) begin
              n.quad = 1'b0;
              n.cont_arm = 1'b0;
              n.burst = `SFC_BURST_RST;
              n.status = (s.status & `SFC_STATUS_KEEP)
                       | (`SFC_STATUS_RST & ~`SFC_STATUS_KEEP);
              n.cfg[`SFC_QUAD_IO_CFG_BIT] = 1'b0;
              n.sw_reset = 1'b1;
              // abort a running program or erase
              n.abort = prog_busy;
            end
            n.rst_arm = 1'b0;
          end
          // four-bit mode for later frames until quad exit or reset
          `SFC_OP_QUAD_ENTER: n.quad = 1'b1;
          `SFC_OP_QUAD_EXIT: begin
            n.quad = 1'b0;
            n.cont_arm = 1'b0;
          end
          `SFC_OP_ID_LOCKOUT: n.status[`SFC_ID_LOCK_BIT] = 1'b1;
          `SFC_OP_SECTOR_ERASE: begin
            n.erase_req = 1'b1;
            n.erase_addr = s.addr & `SFC_SECTOR_MASK;
          end
          `SFC_OP_BLOCK_ERASE: begin
            n.erase_req = 1'b1;
            n.erase_addr = block_base(s.addr);
          end
          `SFC_OP_SUSPEND: n.suspend = 1'b1;
          `SFC_OP_RESUME: n.resume = 1'b1;
          default: ;
        endcase
      end
      // exit byte in a continuation frame only ends continuation
      if (s.in_cont && s.phase == SFC_ADDR && s.nleft == 2'd2 &&
          s.addr[7:0] == `SFC_OP_QUAD_EXIT)
        n.cont_arm = 1'b0;
    end else if (s.phase == SFC_IDLE) begin
      n.in_cont = s.cont_arm;
      n.bcnt = 3'd0;
      n.ocnt = 3'd0;
      // opcode width follows the bus mode
      n.w = s.quad ? 3'd4 : 3'd1;
      if (s.cont_arm) begin
        // no opcode in a continuation frame
        n.phase = SFC_ADDR;
        n.nleft = 2'd3;
        n.opc = `SFC_OP_FAST_READ;
      end else begin
        n.phase = SFC_OPC;
      end
    end else if (rise) begin
      if (s.phase == SFC_END) begin
        // extra clocks after a zero-data opcode void it
        n.phase = SFC_SKIP;
      end else if (s.phase != SFC_DATA && s.phase != SFC_SKIP) begin
        n.sh = b;
        // one byte per 8, 4 or 2 clocks
        n.bcnt = s.bcnt + s.w;
        if (n.bcnt == 3'd0) begin
          unique case (s.phase)
            SFC_OPC: begin
              n.opc = b;
              n.nleft = 2'd3;
              n.phase = SFC_END;
              // any other opcode drops the reset arm
              if (b != `SFC_OP_RESET) n.rst_arm = 1'b0;
              case (b)
                // plain read refused in four-bit mode
                `SFC_OP_READ: n.phase = s.quad ? SFC_SKIP : SFC_ADDR;
                `SFC_OP_FAST_READ,
                `SFC_OP_SECTOR_ERASE,
                `SFC_OP_BLOCK_ERASE: n.phase = SFC_ADDR;
                `SFC_OP_DUAL_READ: begin
                  // two lines from the address on
                  n.phase = s.quad ? SFC_SKIP : SFC_ADDR;
                  n.w = 3'd2;
                end
                `SFC_OP_QUAD_ENTER: n.phase = s.quad ? SFC_SKIP : SFC_END;
                default: ;
              endcase
            end
            SFC_ADDR: begin
              n.addr = {s.addr[15:0], b};
              n.nleft = s.nleft - 2'd1;
              if (s.nleft == 2'd1) begin
                case (s.opc)
                  `SFC_OP_READ: n.phase = SFC_DATA;
                  `SFC_OP_DUAL_READ: n.phase = SFC_MODE;
                  `SFC_OP_FAST_READ: begin
                    n.phase = s.quad ? SFC_MODE : SFC_DUMMY;
                    n.nleft = 2'd1;
                  end
                  default: n.phase = SFC_END;
                endcase
              end
            end
            SFC_MODE: begin
              // upper nibble A arms a continuation frame, for fast read only
              n.cont_arm = s.opc == `SFC_OP_FAST_READ &&
                           b[7:4] == `SFC_CONT_NIBBLE;
              n.phase = (s.opc == `SFC_OP_FAST_READ) ? SFC_DUMMY
                                                     : SFC_DATA;
              n.nleft = 2'd2;
            end
            SFC_DUMMY: begin
              n.nleft = s.nleft - 2'd1;
              if (s.nleft == 2'd1) n.phase = SFC_DATA;
            end
            default: ;
          endcase
        end
      end
    end else if (fall && s.phase == SFC_DATA) begin
      // pointer steps per byte and wraps at the top
      if (s.ocnt == 3'd0) n.addr = s.addr + 24'h1;
      n.obyte = ob << s.w;
      n.ocnt = s.ocnt + s.w;
      if (s.w == 3'd1) begin
        n.sio_o = {2'b00, ob[7], 1'b0};
        n.sio_oe = 4'h2;
      end else if (s.w == 3'd2) begin
        n.sio_o = {2'b00, ob[7:6]};
        n.sio_oe = 4'h3;
      end else begin
        n.sio_o = ob[7:4];
        n.sio_oe = 4'hf;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cs1 <= 1'b1;
      s.cs2 <= 1'b1;
      s.status <= `SFC_STATUS_RST;
      s.cfg <= `SFC_CFG_RST;
      s.burst <= `SFC_BURST_RST;
    end else begin
      s <= n;
    end
  end

  assign link.dev_o = s.sio_o;
  assign link.dev_oe = s.sio_oe;
  assign quad_mode = s.quad;
  assign cont_read = s.cont_arm;
  assign status = s.status;
  assign config_reg = s.cfg;
  assign burst_len = s.burst;
  assign erase_req = s.erase_req;
  assign erase_addr = s.erase_addr;
  assign suspend_req = s.suspend;
  assign resume_req = s.resume;
  assign op_abort = s.abort;
  assign sw_reset_done = s.sw_reset;
endmodule

// >>> design/sfc_host.sv
// host controller: AHB-Lite command registers driving the serial link
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_host
  import sfc_pkg::*;
#(
  parameter int unsigned HALF_DIV = 8
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  sfc_link_if.host         link
);
  // never faster than the plain read limit
  localparam int unsigned HALF_EFF = (HALF_DIV < `SFC_READ_HALF_MIN) ?
                                     `SFC_READ_HALF_MIN : HALF_DIV;
  localparam logic [7:0] HALF_CNT = 8'(HALF_EFF - 1);

  sfc_host_s   s;
  sfc_host_s   n;
  logic        load;
  logic        enter;
  logic        drv;
  logic [2:0]  k;
  logic [3:0]  rdin;

  // first stage at or after k that has bytes to move
  function automatic sfc_hstage_e pick(input logic [2:0] k,
                                       input logic [31:0] c);
    sfc_hstage_e r;
    r = SFC_H_END;
    if (k <= 3'd3 && c[`SFC_CMD_NRD_LSB +: 8] != 8'h00) r = SFC_H_RD;
    if (k <= 3'd2 && c[`SFC_CMD_NDUM_LSB +: 3] != 3'd0) r = SFC_H_DUM;
    if (k <= 3'd1 && c[`SFC_CMD_NADR_LSB +: 2] != 2'd0) r = SFC_H_ADR;
    if (k == 3'd0 && !c[`SFC_CMD_SKIP_OP]) r = SFC_H_OP;
    return r;
  endfunction

  always_comb begin
    n = s;
    load = 1'b0;
    enter = 1'b0;
    drv = 1'b0;
    k = 3'd4;
    n.io1 = link.sio;
    n.io2 = s.io1;
    rdin = (s.w == 3'd1) ? {3'b000, s.io2[1]} : s.io2;
    if (s.a_act && s.a_wr) begin
      if (s.a_off == `SFC_REG_CMD && !s.busy && hwdata[`SFC_CMD_START]) begin
        n.cmd = hwdata;
        n.outsr = s.addr_reg[23:0];
        n.stage = pick(3'd0, hwdata);
        n.cs_n = 1'b0;
        n.sck = 1'b0;
        n.busy = 1'b1;
        n.div = HALF_CNT;
        load = 1'b1;
        enter = 1'b1;
        drv = 1'b1;
      end
      if (s.a_off == `SFC_REG_ADDR) n.addr_reg = hwdata;
    end
    if (s.stage != SFC_H_IDLE) begin
      if (s.div != 8'h00) begin
        n.div = s.div - 8'h01;
      end else begin
        n.div = HALF_CNT;
        unique case (s.stage)
          SFC_H_END: begin
            // every command is its own framed transfer
            n.cs_n = 1'b1;
            n.sio_oe = 4'h0;
            n.stage = SFC_H_GAP;
          end
          SFC_H_GAP: begin
            n.stage = SFC_H_IDLE;
            n.busy = 1'b0;
          end
          default: begin
            if (!s.sck) begin
              n.sck = 1'b1;
            end else begin
              n.sck = 1'b0;
              drv = 1'b1;
              if (s.stage == SFC_H_RD) n.sh = sfc_shift_in(s.sh, rdin, s.w);
              n.bcnt = s.bcnt + s.w;
              if (n.bcnt == 3'd0) begin
                if (s.stage == SFC_H_RD) n.rdata = {s.rdata[23:0], n.sh};
                n.nleft = s.nleft - 8'h01;
                load = 1'b1;
                if (s.nleft == 8'h01) begin
                  unique case (s.stage)
                    SFC_H_OP: k = 3'd1;
                    SFC_H_ADR: k = 3'd2;
                    SFC_H_DUM: k = 3'd3;
                    default: k = 3'd4;
                  endcase
                  n.stage = pick(k, s.cmd);
                  enter = 1'b1;
                end
              end
            end
          end
        endcase
      end
    end
    if (load) begin
      if (enter) begin
        unique case (n.stage)
          SFC_H_ADR: n.nleft = {6'h00, n.cmd[`SFC_CMD_NADR_LSB +: 2]};
          SFC_H_DUM: n.nleft = {5'h00, n.cmd[`SFC_CMD_NDUM_LSB +: 3]};
          SFC_H_RD: n.nleft = n.cmd[`SFC_CMD_NRD_LSB +: 8];
          default: n.nleft = 8'h01;
        endcase
      end
      n.w = (n.stage == SFC_H_OP) ? sfc_lanes(n.cmd[`SFC_CMD_OPL_LSB +: 2])
                                  : sfc_lanes(n.cmd[`SFC_CMD_DATL_LSB +: 2]);
      unique case (n.stage)
        SFC_H_OP: n.sh = n.cmd[7:0];
        SFC_H_ADR: begin
          // address goes out most significant byte first
          n.sh = n.outsr[23:16];
          n.outsr = {n.outsr[15:0], 8'h00};
        end
        SFC_H_DUM: n.sh = s.addr_reg[31:24];
        default: n.sh = 8'h00;
      endcase
    end
    if (drv) begin
      if (n.stage == SFC_H_OP || n.stage == SFC_H_ADR ||
          n.stage == SFC_H_DUM) begin
        // idle lines held high, never left floating
        if (n.w == 3'd1) n.sio_o = {3'b111, n.sh[7]};
        else if (n.w == 3'd2) n.sio_o = {2'b11, n.sh[7:6]};
        else n.sio_o = n.sh[7:4];
        n.sio_oe = 4'hf;
        n.sh = n.sh << n.w;
      end else begin
        n.sio_oe = 4'h0;
      end
    end
    n.a_act = hsel & htrans[1] & hready & (hsize == 3'b010);
    n.a_wr = hwrite;
    n.a_off = {haddr[4:2], 2'b00};
    // read data follows any write finishing in this cycle
    unique case ({haddr[4:2], 2'b00})
      `SFC_REG_CMD: n.hrdata = n.cmd;
      `SFC_REG_ADDR: n.hrdata = n.addr_reg;
      `SFC_REG_STAT: n.hrdata = {31'h0, n.busy};
      `SFC_REG_RDATA: n.hrdata = n.rdata;
      default: n.hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cs_n <= 1'b1;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.cs_n = s.cs_n;
  assign link.sck = s.sck;
  assign link.host_o = s.sio_o;
  assign link.host_oe = s.sio_oe;
  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
endmodule

// >>> dv/sfc_link_assertions.sv
// link checks between the host controller and the flash front end
`timescale 1ns/10ps
module sfc_link_assertions #(
  parameter int unsigned HALF_DIV = 8
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] sio
);
  logic [7:0] hi_cnt;
  logic [7:0] rise_cnt;
  logic       sck_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt <= 8'h00;
      rise_cnt <= 8'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
      hi_cnt <= sck ? hi_cnt + 8'h01 : 8'h00;
      // saturate so a long read never looks like a fresh opcode
      if (cs_n) begin
        rise_cnt <= 8'h00;
      end else if (sck && !sck_q && rise_cnt != 8'hff) begin
        rise_cnt <= rise_cnt + 8'h01;
      end
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence deselect_s;
    $rose(cs_n);
  endsequence
  sequence idle_s;
    cs_n [*6];
  endsequence

  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock moves outside a frame");
  half_period_a: assert property ($fell(sck) |-> hi_cnt == 8'(HALF_DIV))
    else $error("serial clock high phase has wrong length");
  host_hold_a: assert property (sck && $past(sck) |-> $stable(host_o))
    else $error("host data changed while clock high");
  cs_frame_a: assert property ($rose(sck) |-> !cs_n)
    else $error("clock edge without chip select");
  no_fight_a: assert property ((dev_oe & host_oe) == 4'h0)
    else $error("host and device drive one line");
  opc_quiet_a: assert property (
    !cs_n && rise_cnt < 8'h08 |-> dev_oe == 4'h0)
    else $error("device drives during opcode");
  dev_edge_a: assert property (
    dev_oe != 4'h0 && $changed(dev_o) |-> !sck)
    else $error("device data changed while clock high");
  host_lines_a: assert property (
    host_oe != 4'h0 |-> host_oe == 4'hf && sio == host_o)
    else $error("host leaves a line floating");
  release_a: assert property (deselect_s |-> ##[0:5] dev_oe == 4'h0)
    else $error("device still drives after deselect");
  idle_quiet_a: assert property (idle_s |-> dev_oe == 4'h0)
    else $error("device drives while deselected");
endmodule

// >>> dv/sfc_tb_top.sv
// testbench: register bus drives host, host talks to flash front end
`timescale 1ns/10ps
`include "sfc_params.svh"
module sfc_tb_top;
  localparam int unsigned HDIV = 8;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        prog_busy;
  logic        quad_mode;
  logic        cont_read;
  logic [7:0]  status;
  logic [7:0]  config_reg;
  logic [1:0]  burst_len;
  logic        erase_req;
  logic [23:0] erase_addr;
  logic        suspend_req;
  logic        resume_req;
  logic        op_abort;
  logic        sw_reset_done;
  int          failures = 0;
  int          n_compared = 0;
  int          n_rst = 0;
  int          n_abt = 0;
  int          n_ers = 0;
  int          n_sus = 0;
  int          n_res = 0;

  sfc_link_if sfc_link_if_inst ();
  sfc_host #(.HALF_DIV(HDIV)) sfc_host_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(sfc_link_if_inst));
  sfc_dev sfc_dev_inst (
    .hclk(hclk), .hresetn(hresetn), .link(sfc_link_if_inst),
    .prog_busy(prog_busy), .quad_mode(quad_mode), .cont_read(cont_read),
    .status(status), .config_reg(config_reg), .burst_len(burst_len),
    .erase_req(erase_req), .erase_addr(erase_addr),
    .suspend_req(suspend_req), .resume_req(resume_req),
    .op_abort(op_abort), .sw_reset_done(sw_reset_done));
  sfc_link_assertions #(.HALF_DIV(HDIV)) sfc_link_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .cs_n(sfc_link_if_inst.cs_n),
    .sck(sfc_link_if_inst.sck), .host_o(sfc_link_if_inst.host_o),
    .host_oe(sfc_link_if_inst.host_oe), .dev_o(sfc_link_if_inst.dev_o),
    .dev_oe(sfc_link_if_inst.dev_oe), .sio(sfc_link_if_inst.sio));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // pulses last one cycle, so count them as they pass
  always @(posedge hclk) begin
    if (sw_reset_done === 1'b1) n_rst++;
    if (op_abort === 1'b1) n_abt++;
    if (erase_req === 1'b1) n_ers++;
    if (suspend_req === 1'b1) n_sus++;
    if (resume_req === 1'b1) n_res++;
  end

  function automatic logic [7:0] df(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction

  function automatic logic [31:0] cw(input logic [7:0] op,
                                     input logic [1:0] ln,
                                     input logic [1:0] na,
                                     input logic [2:0] nd,
                                     input logic [7:0] nr);
    return {1'b1, 6'h00, nr, nd, na, ln, ln, op};
  endfunction

  task automatic complete_run;
    $display("failures=%0d compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr <= {27'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // one frame; the watchdog bounds the busy poll
  task automatic run(input logic [31:0] c, input logic [31:0] a);
    logic [31:0] r;
    ahb(1'b1, `SFC_REG_ADDR, a, r);
    ahb(1'b1, `SFC_REG_CMD, c, r);
    do ahb(1'b0, `SFC_REG_STAT, 32'h0, r); while (r[0] !== 1'b0);
    repeat (12) @(posedge hclk);
  endtask

  task automatic t_read_wrap;
    logic [31:0] r;
    run(cw(`SFC_OP_READ, 2'd0, 2'd3, 3'd0, 8'd4), 32'h00ff_fffe);
    ahb(1'b0, `SFC_REG_RDATA, 32'h0, r);
    chk(r, {df(24'hfffffe), df(24'hffffff), df(24'h0), df(24'h1)},
        "read stream");
    run(cw(`SFC_OP_DUAL_READ, 2'd1, 2'd3, 3'd1, 8'd4) & ~32'h300,
        32'h12_3456);
    ahb(1'b0, `SFC_REG_RDATA, 32'h0, r);
    chk(r, {df(24'h123456), df(24'h123457), df(24'h123458),
            df(24'h123459)}, "dual read");
    chk(32'(hresp), 32'h0, "bus error response");
  endtask

  task automatic t_quad;
    logic [31:0] r;
    run(cw(`SFC_OP_QUAD_ENTER, 2'd0, 2'd0, 3'd0, 8'd1), 32'h0);
    chk(32'(quad_mode), 32'h0, "extra clock not voiding");
    run(cw(`SFC_OP_QUAD_ENTER, 2'd0, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(quad_mode), 32'h1, "quad enter");
    run(cw(`SFC_OP_READ, 2'd2, 2'd3, 3'd0, 8'd4), 32'h0);
    ahb(1'b0, `SFC_REG_RDATA, 32'h0, r);
    chk(r, 32'hffff_ffff, "plain read in quad");
    chk(32'(quad_mode), 32'h1, "quad lost");
    run(cw(`SFC_OP_ID_LOCKOUT, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(status[5]), 32'h1, "lockout in quad");
  endtask

  task automatic t_reset;
    run(cw(`SFC_OP_RESET_ARM, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    run(cw(`SFC_OP_NO_EFFECT, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    run(cw(`SFC_OP_RESET, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(n_rst), 32'h0, "reset without arm");
    chk(32'(quad_mode), 32'h1, "no-effect changed mode");
    @(posedge hclk);
    prog_busy <= 1'b1;
    run(cw(`SFC_OP_RESET_ARM, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    run(cw(`SFC_OP_RESET, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(n_rst), 32'h1, "reset missing");
    chk(32'(n_abt), 32'h1, "abort missing");
    chk(32'(quad_mode), 32'h0, "mode after reset");
    chk(32'(status), 32'h20, "status after reset");
    chk(32'(config_reg[1]), 32'h0, "config after reset");
    chk(32'(burst_len), 32'h0, "burst after reset");
    prog_busy <= 1'b0;
  endtask

  task automatic t_exit;
    run(cw(`SFC_OP_QUAD_ENTER, 2'd0, 2'd0, 3'd0, 8'd0), 32'h0);
    run(cw(`SFC_OP_FAST_READ, 2'd2, 2'd3, 3'd3, 8'd1), 32'ha500_0010);
    chk(32'(cont_read), 32'h1, "continuation");
    run(cw(`SFC_OP_QUAD_EXIT, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'({cont_read, quad_mode}), 32'h1, "first exit");
    run(cw(`SFC_OP_QUAD_EXIT, 2'd2, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(quad_mode), 32'h0, "second exit");
  endtask

  task automatic t_erase;
    logic [7:0]  op[4] = '{8'h20, 8'hd8, 8'hd8, 8'hd8};
    logic [23:0] a[4] = '{24'h123456, 24'h123456, 24'h009abc, 24'h003456};
    logic [23:0] e[4] = '{24'h123000, 24'h120000, 24'h008000, 24'h002000};
    for (int i = 0; i < 4; i++) begin
      run(cw(op[i], 2'd0, 2'd3, 3'd0, 8'd0), {8'h00, a[i]});
      chk(32'(erase_addr), 32'(e[i]), "erase base");
      chk(32'(n_ers), 32'(i + 1), "erase request");
    end
    run(cw(`SFC_OP_SUSPEND, 2'd0, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(n_sus), 32'h1, "suspend");
    run(cw(`SFC_OP_RESUME, 2'd0, 2'd0, 3'd0, 8'd0), 32'h0);
    chk(32'(n_res), 32'h1, "resume");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    prog_busy = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_read_wrap();
    t_quad();
    t_reset();
    t_exit();
    t_erase();
    complete_run();
  end

  // about 20 frames of at most 1100 cycles each fit well inside
  initial begin
    #1_000_000;
    failures++;
    complete_run();
  end
endmodule
